// ===== hw/timer0_compare_output_regs.sv
// 8-bit timer/counter with compare output unit and its registers.
// Assumes a single-cycle I/O bus request and synchronous pin inputs.
`timescale 1ns/1ns
module timer0_compare_output_regs import timer0_pkg::*; (
	input  wire logic       CLK,
	input  wire logic       ARST_N,
	input  wire io_req_type IO_REQ,
	input  wire logic       GIE,
	input  wire logic       CMP_VEC_ACK,
	input  wire logic       OVF_VEC_ACK,
	input  wire logic       EXT_COUNT_PIN,
	input  wire logic       PORT_DATA,
	input  wire logic       DIR_BIT,
	output logic [7:0]      IO_RDATA,
	output logic            CMP_IRQ,
	output logic            OVF_IRQ,
	output logic            WAVE_PIN_O,
	output logic            WAVE_PIN_OE
);

	logic [7:0]    compare_reg;
	logic [7:0]    count_reg;
	logic [7:0]    count_next;
	logic [6:0]    ctl_reg;
	logic [1:0]    flags_reg;
	logic [1:0]    mask_reg;
	dir_type       dir_reg;
	dir_type       dir_next;
	logic          block_reg;
	logic          oc_reg;
	logic          oc_next;
	logic          ext_s1_reg;
	logic          ext_s2_reg;
	logic          ext_s3_reg;
	logic          ext_fall;
	logic          tick;
	logic          ovf_evt;
	logic          cmp_evt;
	reg_sel_type   sel;
	wave_mode_type mode;
	logic [1:0]    com;
	logic          at_max;
	logic          at_bottom;
	logic          equal;
	logic          ignore_match;
	logic          force_wr;
	logic          wr_counter;
	logic          wr_control;
	logic          clr_cmp;
	logic          clr_ovf;

	function automatic reg_sel_type decode(input io_req_type r);
		logic [6:0] ofs;
		ofs = r.data_space ? r.addr - DATA_SPACE_OFS : r.addr;
		if (r.data_space && r.addr < DATA_SPACE_OFS) begin
			ofs = IO_SPACE_LAST;
		end
		case (ofs)
			ADDR_COMPARE: return SEL_COMPARE;
			ADDR_COUNTER: return SEL_COUNTER;
			ADDR_CONTROL: return SEL_CONTROL;
			ADDR_FLAGS:   return SEL_FLAGS;
			ADDR_MASK:    return SEL_MASK;
			default:      return SEL_NONE;
		endcase
	endfunction

	function automatic logic apply(input logic oc, input logic [1:0] code);
		case (code)
			COM_TOGGLE: return ~oc;
			COM_CLEAR:  return 1'b0;
			COM_SET:    return 1'b1;
			default:    return oc;
		endcase
	endfunction

	assign sel = decode(IO_REQ);
	assign wr_counter = IO_REQ.wr && sel == SEL_COUNTER;
	assign wr_control = IO_REQ.wr && sel == SEL_CONTROL;
	assign mode = wave_mode_type'({ctl_reg[CTL_WGM1_BIT],
		ctl_reg[CTL_WGM0_BIT]});
	assign com = ctl_reg[CTL_COM_HI:CTL_COM_LO];
	assign at_max = count_reg == TOP_MAX;
	assign at_bottom = count_reg == BOTTOM;
	assign equal = count_reg == compare_reg;
	assign cmp_evt = tick && equal && !block_reg;
	assign ignore_match = compare_reg == TOP_MAX && com[1];
	assign force_wr = wr_control && IO_REQ.wdata[CTL_FORCE_BIT]
		&& (mode == WM_NORMAL || mode == WM_CTC);
	assign clr_cmp = (IO_REQ.wr && sel == SEL_FLAGS
		&& IO_REQ.wdata[FLAG_CMP_BIT]) || CMP_VEC_ACK;
	assign clr_ovf = (IO_REQ.wr && sel == SEL_FLAGS
		&& IO_REQ.wdata[FLAG_OVF_BIT]) || OVF_VEC_ACK;

	// The pin is sampled whatever its direction, so software driving it
	// as an output still advances the counter.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
		end else begin
			ext_s1_reg <= EXT_COUNT_PIN;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end

	assign ext_fall = ext_s3_reg && !ext_s2_reg;

	timer0_prescaler u_prescaler (
		.clk      (CLK),
		.arst_n   (ARST_N),
		.clk_sel  (ctl_reg[CTL_CS_HI:0]),
		.ext_fall (ext_fall),
		.tick     (tick)
	);

	always_comb begin
		count_next = count_reg;
		dir_next = dir_reg;
		ovf_evt = 1'b0;
		if (wr_counter) begin
			count_next = IO_REQ.wdata;
		end else if (tick) begin
			case (mode)
				WM_PHASE: begin
					if (dir_reg == DIR_UP) begin
						if (at_max) begin
							dir_next = DIR_DOWN;
							count_next = count_reg - 8'h01;
						end else begin
							count_next = count_reg + 8'h01;
						end
					end else if (at_bottom) begin
						dir_next = DIR_UP;
						count_next = count_reg + 8'h01;
						ovf_evt = 1'b1;
					end else begin
						count_next = count_reg - 8'h01;
					end
				end
				WM_CTC: begin
					count_next = cmp_evt ? BOTTOM : count_reg + 8'h01;
					ovf_evt = at_max && !cmp_evt;
				end
				default: begin
					count_next = count_reg + 8'h01;
					ovf_evt = at_max;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			count_reg <= RESET_BYTE;
			dir_reg <= DIR_UP;
		end else begin
			count_reg <= count_next;
			dir_reg <= (mode == WM_PHASE) ? dir_next : DIR_UP;
		end
	end

	// Held until the next timer tick, so a slow prescale still blocks.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			block_reg <= 1'b0;
		end else if (wr_counter) begin
			block_reg <= 1'b1;
		end else if (tick) begin
			block_reg <= 1'b0;
		end
	end

	always_comb begin
		oc_next = oc_reg;
		case (mode)
			WM_FAST: begin
				if (tick && at_max && com[1]) begin
					oc_next = apply(oc_reg, {1'b1, ~com[0]});
				end else if (cmp_evt && com[1] && !ignore_match) begin
					oc_next = apply(oc_reg, com);
				end
			end
			WM_PHASE: begin
				if (com[1] && cmp_evt && !ignore_match) begin
					oc_next = (dir_reg == DIR_UP) ? apply(oc_reg, com)
						: apply(oc_reg, {1'b1, ~com[0]});
				end else if (com[1] && ignore_match && tick && at_max
					&& dir_reg == DIR_UP) begin
					oc_next = apply(oc_reg, {1'b1, ~com[0]});
				end
			end
			default: begin
				if (force_wr || cmp_evt) begin
					oc_next = apply(oc_reg, com);
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			oc_reg <= 1'b0;
		end else begin
			oc_reg <= oc_next;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			WAVE_PIN_O <= 1'b0;
			WAVE_PIN_OE <= 1'b0;
		end else begin
			WAVE_PIN_O <= (com != COM_OFF) ? oc_reg : PORT_DATA;
			WAVE_PIN_OE <= DIR_BIT;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			compare_reg <= RESET_BYTE;
			ctl_reg <= RESET_BYTE[6:0];
			mask_reg <= RESET_BYTE[1:0];
		end else if (IO_REQ.wr) begin
			if (sel == SEL_COMPARE) begin
				compare_reg <= IO_REQ.wdata;
			end
			if (sel == SEL_CONTROL) begin
				ctl_reg <= IO_REQ.wdata[6:0];
			end
			if (sel == SEL_MASK) begin
				mask_reg <= IO_REQ.wdata[1:0];
			end
		end
	end

	// Hardware set is ORed in after the clear so an event is never lost.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			flags_reg <= RESET_BYTE[1:0];
		end else begin
			flags_reg[FLAG_CMP_BIT] <= cmp_evt
				|| (flags_reg[FLAG_CMP_BIT] && !clr_cmp);
			flags_reg[FLAG_OVF_BIT] <= ovf_evt
				|| (flags_reg[FLAG_OVF_BIT] && !clr_ovf);
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CMP_IRQ <= 1'b0;
			OVF_IRQ <= 1'b0;
		end else begin
			CMP_IRQ <= flags_reg[FLAG_CMP_BIT] && mask_reg[FLAG_CMP_BIT]
				&& GIE;
			OVF_IRQ <= flags_reg[FLAG_OVF_BIT] && mask_reg[FLAG_OVF_BIT]
				&& GIE;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			IO_RDATA <= RESET_BYTE;
		end else if (IO_REQ.rd) begin
			case (sel)
				SEL_COMPARE: IO_RDATA <= compare_reg;
				SEL_COUNTER: IO_RDATA <= count_reg;
				SEL_CONTROL: IO_RDATA <= {1'b0, ctl_reg};
				SEL_FLAGS:   IO_RDATA <= {6'h00, flags_reg};
				SEL_MASK:    IO_RDATA <= {6'h00, mask_reg};
				default:     IO_RDATA <= RESET_BYTE;
			endcase
		end else begin
			IO_RDATA <= RESET_BYTE;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	sequence s_ext_fall;
		ext_s2_reg ##1 !ext_s2_reg;
	endsequence

	sequence s_write_then_tick;
		wr_counter ##1 tick;
	endsequence

	a_pin_route: assert property (
		com != COM_OFF ##1 com != COM_OFF |-> WAVE_PIN_O == $past(oc_reg))
		else $error("wave output not routed to pin");

	a_toggle_match: assert property (
		mode == WM_NORMAL && com == COM_TOGGLE && cmp_evt
		|=> oc_reg != $past(oc_reg))
		else $error("toggle on match missed");

	a_fast_bottom: assert property (
		mode == WM_FAST && com == COM_CLEAR && tick && at_max |=> oc_reg)
		else $error("fast mode bottom set missed");

	// The match at top must lose to the bottom action, else the level flips.
	a_fast_const: assert property (
		mode == WM_FAST && com[1] && ignore_match && tick && at_max
		|=> oc_reg == !$past(com[0]))
		else $error("fast mode top compare not ignored");

	a_phase_up: assert property (
		mode == WM_PHASE && com == COM_CLEAR && cmp_evt
		&& !ignore_match && dir_reg == DIR_UP |=> !oc_reg)
		else $error("phase mode up-match clear missed");

	a_phase_top: assert property (
		mode == WM_PHASE && com == COM_CLEAR && ignore_match && tick
		&& at_max && dir_reg == DIR_UP |=> oc_reg)
		else $error("phase mode top action missed");

	// The tick is registered, so a stop takes one cycle to reach the count.
	a_stop_hold: assert property (
		ctl_reg[CTL_CS_HI:0] == CS_STOP ##1 !wr_counter
		|=> $stable(count_reg))
		else $error("counter moved while stopped");

	a_ext_edge: assert property (
		s_ext_fall ##0 ctl_reg[CTL_CS_HI:1] == 2'h3 |=> tick)
		else $error("external falling edge not counted");

	a_write_block: assert property (
		s_write_then_tick |-> !cmp_evt)
		else $error("match after counter write not blocked");

	a_flag_set: assert property (
		cmp_evt |=> flags_reg[FLAG_CMP_BIT])
		else $error("compare flag not set on match");

	a_phase_ovf: assert property (
		mode == WM_PHASE && tick && dir_reg == DIR_DOWN && at_bottom
		&& !wr_counter |=> flags_reg[FLAG_OVF_BIT] ##0 dir_reg == DIR_UP)
		else $error("phase mode bottom overflow missed");

	a_cmp_irq: assert property (
		flags_reg[FLAG_CMP_BIT] && mask_reg[FLAG_CMP_BIT] && GIE
		|=> CMP_IRQ)
		else $error("compare interrupt not raised");

endmodule // timer0_compare_output_regs

// ===== hw/timer0_pkg.sv
// Shared constants and types of the 8-bit timer with compare output.
// Assumes an 8-bit processor I/O bus with separate I/O and data spaces.
package timer0_pkg;

	localparam logic [6:0] ADDR_COMPARE   = 7'h23;
	localparam logic [6:0] ADDR_COUNTER   = 7'h24;
	localparam logic [6:0] ADDR_CONTROL   = 7'h25;
	localparam logic [6:0] ADDR_FLAGS     = 7'h36;
	localparam logic [6:0] ADDR_MASK      = 7'h37;
	localparam logic [6:0] DATA_SPACE_OFS = 7'h20;
	localparam logic [6:0] IO_SPACE_LAST  = 7'h3f;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] TOP_MAX    = 8'hff;
	localparam logic [7:0] BOTTOM     = 8'h00;

	localparam int CTL_FORCE_BIT = 7;
	localparam int CTL_WGM0_BIT  = 6;
	localparam int CTL_COM_HI    = 5;
	localparam int CTL_COM_LO    = 4;
	localparam int CTL_WGM1_BIT  = 3;
	localparam int CTL_CS_HI     = 2;
	localparam int FLAG_CMP_BIT  = 1;
	localparam int FLAG_OVF_BIT  = 0;

	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam logic [2:0] CS_DIV1    = 3'h1;
	localparam logic [2:0] CS_DIV8    = 3'h2;
	localparam logic [2:0] CS_DIV64   = 3'h3;
	localparam logic [2:0] CS_DIV256  = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_A   = 3'h6;
	localparam logic [2:0] CS_EXT_B   = 3'h7;

	localparam int PRESCALE_W = 10;
	localparam logic [9:0] DIV8_MASK    = 10'h007;
	localparam logic [9:0] DIV64_MASK   = 10'h03f;
	localparam logic [9:0] DIV256_MASK  = 10'h0ff;
	localparam logic [9:0] DIV1024_MASK = 10'h3ff;

	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;

	typedef enum logic [1:0] {
		WM_NORMAL,
		WM_PHASE,
		WM_CTC,
		WM_FAST
	} wave_mode_type;

	typedef enum logic {DIR_UP, DIR_DOWN} dir_type;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_COMPARE,
		SEL_COUNTER,
		SEL_CONTROL,
		SEL_FLAGS,
		SEL_MASK
	} reg_sel_type;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       data_space;
		logic [6:0] addr;
		logic [7:0] wdata;
	} io_req_type;

endpackage

// ===== hw/timer0_prescaler.sv
// Clock-select prescaler: turns the selected source into a tick pulse.
// Assumes ext_fall is already a one-cycle synchronous edge pulse.
`timescale 1ns/1ns
module timer0_prescaler import timer0_pkg::*; (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [2:0] clk_sel,
	input  wire logic       ext_fall,
	output logic            tick
);

	logic [PRESCALE_W-1:0] pre_cnt_reg;

	function automatic logic hit(input logic [9:0] cnt,
		input logic [9:0] mask);
		return (cnt & mask) == mask;
	endfunction

	// Free running; the taps share one counter, so a rate change takes
	// effect at the next tap boundary rather than restarting the period.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_cnt_reg <= '0;
		end else begin
			pre_cnt_reg <= pre_cnt_reg + 10'h001;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tick <= 1'b0;
		end else begin
			case (clk_sel)
				CS_STOP:    tick <= 1'b0;
				CS_DIV1:    tick <= 1'b1;
				CS_DIV8:    tick <= hit(pre_cnt_reg, DIV8_MASK);
				CS_DIV64:   tick <= hit(pre_cnt_reg, DIV64_MASK);
				CS_DIV256:  tick <= hit(pre_cnt_reg, DIV256_MASK);
				CS_DIV1024: tick <= hit(pre_cnt_reg, DIV1024_MASK);
				default:    tick <= ext_fall;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_div8_gap: assert property (
		clk_sel == CS_DIV8 && pre_cnt_reg[2:0] != 3'h7 |=> !tick)
		else $error("divide-by-8 tick outside its slot");

	a_stop_quiet: assert property (
		clk_sel == CS_STOP |=> !tick)
		else $error("tick while clock stopped");

endmodule // timer0_prescaler

// ===== verification/timer0_compare_output_regs_tb_top.sv
// Self-checking bench for the 8-bit timer with compare output and registers.
// Assumes the timer package and the design top are compiled before it.
`timescale 1ns/1ns
module timer0_compare_output_regs_tb_top import timer0_pkg::*;;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	io_req_type io_req = '0;
	logic       gie = 1'b1;
	logic       cmp_ack = 1'b0;
	logic       ovf_ack = 1'b0;
	logic       ext_pin = 1'b1;
	logic       port_data = 1'b1;
	logic       dir_bit = 1'b1;
	logic [7:0] rdata;
	logic       cmp_irq;
	logic       ovf_irq;
	logic       wave_o;
	logic       wave_oe;
	int         n_fail = 0;
	int         checks_done = 0;
	int         cyc = 0;

	timer0_compare_output_regs dut (
		.CLK          (clk),
		.ARST_N       (arst_n),
		.IO_REQ       (io_req),
		.GIE          (gie),
		.CMP_VEC_ACK  (cmp_ack),
		.OVF_VEC_ACK  (ovf_ack),
		.EXT_COUNT_PIN(ext_pin),
		.PORT_DATA    (port_data),
		.DIR_BIT      (dir_bit),
		.IO_RDATA     (rdata),
		.CMP_IRQ      (cmp_irq),
		.OVF_IRQ      (ovf_irq),
		.WAVE_PIN_O   (wave_o),
		.WAVE_PIN_OE  (wave_oe)
	);

	always #5 clk = ~clk;

	// The whole run needs about 30000 cycles, so this only cuts a hang.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic chk_rng(string nm, int lo, int hi, logic [31:0] g);
		checks_done++;
		if ($isunknown(g) || g < lo || g > hi) begin
			n_fail++;
			$display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask

	// Addresses above the I/O space are sent as data-space accesses.
	task automatic wr(logic [6:0] a, logic [7:0] d);
		@(posedge clk);
		io_req <= '{1'b0, 1'b1, a > IO_SPACE_LAST, a, d};
		@(posedge clk);
		io_req <= '0;
	endtask

	task automatic rd(logic [6:0] a, output logic [7:0] d);
		@(posedge clk);
		io_req <= '{1'b1, 1'b0, a > IO_SPACE_LAST, a, 8'h00};
		@(posedge clk);
		io_req <= '0;
		#1 d = rdata;
	endtask

	task automatic rdchk(logic [6:0] a, logic [7:0] e, string nm);
		logic [7:0] d;
		rd(a, d);
		chk8(nm, e, d);
	endtask

	task automatic pins(logic o, logic oe, string nm);
		repeat (2) @(posedge clk);
		#1 chk8(nm, {6'h00, oe, o}, {6'h00, wave_oe, wave_o});
	endtask

	task automatic t_regs();
		logic [6:0] al [5] = '{7'h23, 7'h24, 7'h25, 7'h36, 7'h37};
		for (int i = 0; i < 5; i++) begin
			rdchk(al[i], RESET_BYTE, "reset value");
		end
		pins(1'b1, 1'b1, "port data shown");
		dir_bit <= 1'b0;
		pins(1'b1, 1'b0, "driver off");
		dir_bit <= 1'b1;
		wr(ADDR_COMPARE + DATA_SPACE_OFS, 8'ha5);
		rdchk(ADDR_COMPARE, 8'ha5, "data space write");
		rdchk(7'h10, 8'h00, "unmapped read");
		wr(ADDR_MASK, 8'hff);
		rdchk(ADDR_MASK, 8'h03, "mask bits");
		wr(ADDR_CONTROL, 8'hb0);
		rdchk(ADDR_CONTROL, 8'h30, "control fields");
	endtask

	task automatic t_force();
		logic [7:0] ctl [3] = '{8'hb0, 8'ha0, 8'h90};
		logic       lv [3] = '{1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_CONTROL, ctl[i] & 8'h7f);
			wr(ADDR_CONTROL, ctl[i]);
			pins(lv[i], 1'b1, "forced level");
		end
		rdchk(ADDR_FLAGS, 8'h00, "force flags");
	endtask

	task automatic t_match();
		logic [7:0] d;
		wr(ADDR_COUNTER, 8'h00);
		wr(ADDR_COMPARE, 8'h10);
		wr(ADDR_CONTROL, 8'h11);
		repeat (40) @(posedge clk);
		wr(ADDR_CONTROL, 8'h10);
		rdchk(ADDR_FLAGS, 8'h02, "match flag");
		pins(1'b0, 1'b1, "toggle on match");
		chk8("cmp irq", 8'h01, {7'h00, cmp_irq});
		gie <= 1'b0;
		pins(1'b0, 1'b1, "pin held");
		chk8("cmp irq gated", 8'h00, {7'h00, cmp_irq});
		gie <= 1'b1;
		@(posedge clk);
		cmp_ack <= 1'b1;
		@(posedge clk);
		cmp_ack <= 1'b0;
		rdchk(ADDR_FLAGS, 8'h00, "vector clears");
		wr(ADDR_COUNTER, 8'hfc);
		wr(ADDR_CONTROL, 8'h01);
		repeat (10) @(posedge clk);
		wr(ADDR_CONTROL, 8'h00);
		rdchk(ADDR_FLAGS, 8'h01, "overflow flag");
		chk8("ovf irq", 8'h01, {7'h00, ovf_irq});
		wr(ADDR_FLAGS, 8'h01);
		rdchk(ADDR_FLAGS, 8'h00, "write one clears");
		chk8("ovf irq off", 8'h00, {7'h00, ovf_irq});
		wr(ADDR_COMPARE, 8'h0f);
		wr(ADDR_CONTROL, 8'h09);
		repeat (100) @(posedge clk);
		wr(ADDR_CONTROL, 8'h08);
		rd(ADDR_COUNTER, d);
		chk_rng("clear on match top", 0, 15, d);
	endtask

	// A running counter rewritten to the compare value must not match next.
	task automatic t_block();
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_COMPARE, 8'h20);
		wr(ADDR_COUNTER, 8'h80);
		wr(ADDR_CONTROL, 8'h01);
		wr(ADDR_FLAGS, 8'h03);
		wr(ADDR_COUNTER, 8'h20);
		repeat (20) @(posedge clk);
		wr(ADDR_CONTROL, 8'h00);
		rdchk(ADDR_FLAGS, 8'h00, "blocked match");
	endtask

	task automatic t_ext();
		for (int c = 6; c < 8; c++) begin
			wr(ADDR_COUNTER, 8'h00);
			wr(ADDR_CONTROL, 8'(c));
			repeat (5) begin
				ext_pin <= 1'b0;
				repeat (3) @(posedge clk);
				ext_pin <= 1'b1;
				repeat (3) @(posedge clk);
			end
			repeat (6) @(posedge clk);
			wr(ADDR_CONTROL, 8'h00);
			rdchk(ADDR_COUNTER, 8'h05, "falling edges");
		end
	endtask

	// The prescaler runs free, so a count may be off by a tick or two.
	task automatic t_rate();
		int n [5] = '{200, 800, 3200, 5120, 10240};
		int e [5] = '{200, 100, 50, 20, 10};
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_COUNTER, 8'h00);
			wr(ADDR_CONTROL, 8'(i + 1));
			repeat (n[i]) @(posedge clk);
			wr(ADDR_CONTROL, 8'h00);
			rd(ADDR_COUNTER, d);
			chk_rng("prescaled count", e[i] - 2, e[i] + 2, d);
		end
	endtask

	task automatic t_pwm(logic [7:0] ctl, logic [7:0] cv, int lo, int hi);
		int hn;
		hn = 0;
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_COUNTER, 8'h00);
		wr(ADDR_COMPARE, cv);
		wr(ADDR_CONTROL, ctl);
		repeat (600) @(posedge clk);
		repeat (1020) begin
			@(negedge clk);
			hn += int'(wave_o);
		end
		chk_rng("pwm high cycles", lo, hi, hn);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_force();
		t_match();
		t_block();
		t_ext();
		t_rate();
		t_pwm(8'h69, 8'h80, 500, 530);
		t_pwm(8'h79, 8'h40, 745, 775);
		t_pwm(8'h69, 8'hff, 1020, 1020);
		t_pwm(8'h61, 8'h80, 500, 525);
		t_pwm(8'h71, 8'h40, 750, 780);
		t_pwm(8'h61, 8'hff, 1020, 1020);
		close_out();
	end
endmodule // timer0_compare_output_regs_tb_top
